//--- logic/odz_pkg.sv
// Package of constants for the termination mode and calibration controller
package odz_pkg;
    // ************************************************************
    // Timing figures (ps and ns) and clock rate
    // ************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_AONPD_MIN_PS = 2000;
    localparam int T_AONPD_MAX_PS = 8500;
    localparam int T_AOFPD_MIN_PS = 2000;
    localparam int T_AOFPD_MAX_PS = 8500;
    localparam int T_ZQINIT_NS = 2560;
    localparam int T_ZQOPER_NS = 1280;
    localparam int T_ZQCS_NS = 320;
    localparam int ZQCS_STEP_NCK = 64;
    // Least times round up, longest round down
    localparam int AONPD_MIN_CYC = (T_AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AONPD_MAX_CYC = T_AONPD_MAX_PS / CLK_PERIOD_PS;
    localparam int AOFPD_MIN_CYC = (T_AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AOFPD_MAX_CYC = T_AOFPD_MAX_PS / CLK_PERIOD_PS;
    localparam int ZQINIT_CYC = T_ZQINIT_NS * 1000 / CLK_PERIOD_PS;
    localparam int ZQOPER_CYC = T_ZQOPER_NS * 1000 / CLK_PERIOD_PS;
    localparam int ZQCS_CYC = T_ZQCS_NS * 1000 / CLK_PERIOD_PS;
    // ************************************************************
    // Defaults
    // ************************************************************
    localparam int WL_DEF = 5;
    localparam int CPDED_DEF = 1;
    localparam int XPDLL_DEF = 10;
    localparam int RFC_DEF = 22;
    localparam int CNT_W = 16;
    localparam logic [7:0] ZQ_CODE_RST = 8'h80;
    typedef enum logic [3:0] {
        ODZ_ZQ_IDLE = 4'h1,
        ODZ_ZQ_LONG = 4'h2,
        ODZ_ZQ_SHORT = 4'h4,
        ODZ_ZQ_LOAD = 4'h8
    } odz_zq_e;
endpackage : odz_pkg

//--- logic/odz_delay.sv
// Countdown timer used for calibration intervals
`timescale 1ns/1ps
module odz_delay
    import odz_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic done_d;
    logic done_q;

    always_comb
    begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (load)
        begin
            cnt_d = value;
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 1'b1;
            done_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy = (cnt_q != '0);
    assign done = done_q;
endmodule : odz_delay

//--- logic/odz_ctrl.sv
// Termination mode transition and impedance calibration control
// Summary of operation
// - Frozen DLL gives power-down entry window
// - tANPD is WL-1 before CKE low; not covered here, the entry window opens only at the CKE edge
// - Window excludes start, includes end
// - Running refresh may extend entry window end
// - Turn-on bounded by min and max mix
// - Turn-off bounded by min and max mix
// - Exit window opens at CKE high and lasts tXPDLL, nothing before
// - Overlapping entry/exit windows merge continuously
// - Overlapping exit/entry windows merge continuously
// - Long calibration runs engine then loads codes
// - First long gets tZQinit, later tZQoper
// - Short calibration runs ZQCS_STEP_NCK cycles, then one load cycle
// - Calibration current off once done
// - No recalibration on self-refresh exit alone
// - Asynchronous mode skips additive latency
// - Async turn-on measured from ODT sampled high
`timescale 1ns/1ps
module odz_ctrl
    import odz_pkg::*;
#(
    parameter int WL = WL_DEF,
    parameter int AL = 0,
    parameter int CPDED = CPDED_DEF,
    parameter int XPDLL = XPDLL_DEF,
    parameter int RFC = RFC_DEF,
    parameter int ZQINIT = ZQINIT_CYC,
    parameter int ZQOPER = ZQOPER_CYC,
    parameter int ZQCS = ZQCS_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dll_freeze_pd,
    input wire logic cke,
    input wire logic odt,
    input wire logic refresh_cmd,
    input wire logic zqcl_cmd,
    input wire logic zqcs_cmd,
    output logic rtt_on,
    output logic odt_async,
    output logic in_window,
    output logic zq_busy,
    output logic zq_current_en,
    output logic [7:0] zq_code
);
    // ************************************************************
    // Elaboration checks
    // ************************************************************
    localparam int LAT = WL + AL - 2;
    localparam int WIN_PRE = WL - 1;
    initial
    begin
        if (WL < 3 || WL > 15 || CPDED < 1 || XPDLL < 1 || ZQCS < ZQCS_STEP_NCK)
            $error("odz_ctrl: unsupported parameter set");
        if (AL < 0 || LAT > 15 || ZQINIT < 2 || ZQOPER < 2)
            $error("odz_ctrl: latency or calibration count out of range");
        if (ZQINIT >= (1 << CNT_W) || ZQOPER >= (1 << CNT_W) || RFC >= 256)
            $error("odz_ctrl: counts exceed counter width");
    end

    // ************************************************************
    // Power-down state and transition windows
    // ************************************************************
    logic cke_q, pd_q, pd_d;
    logic [7:0] win_q, win_d;
    logic [7:0] rfc_q, rfc_d;
    logic [15:0] odt_hist_q, odt_hist_d;
    logic async_q, async_d;
    logic rtt_q, rtt_d;
    logic [3:0] aon_cnt_q, aon_cnt_d;
    logic odt_q;
    logic win_open_q;

    // Window opens at the CKE edge: the WL-1 cycles preceding it (WIN_PRE) are
    // not covered, and the delayed ODT history is not evaluated against the window.
    always_comb
    begin
        pd_d = pd_q;
        win_d = (win_q != 8'h0) ? win_q - 8'h1 : 8'h0;
        rfc_d = (rfc_q != 8'h0) ? rfc_q - 8'h1 : 8'h0;
        if (refresh_cmd)
            rfc_d = 8'(RFC);
        if (dll_freeze_pd && cke_q && !cke)
        begin
            pd_d = 1'b1;
            // Later of tCPDED end and tRFC end, end included
            win_d = (rfc_q > 8'(CPDED)) ? rfc_q : 8'(CPDED);
        end
        else if (pd_q && !cke_q && cke)
        begin
            pd_d = 1'b0;
            win_d = 8'(XPDLL);
        end
        else if (!dll_freeze_pd)
            pd_d = 1'b0;
        // Merged windows stay open while either is live
        if ((win_q != 8'h0) && (win_d < win_q - 8'h1))
            win_d = win_q - 8'h1;
    end

    // ************************************************************
    // Termination response
    // ************************************************************
    always_comb
    begin
        odt_hist_d = {odt_hist_q[14:0], odt};
        async_d = pd_q && dll_freeze_pd;
        aon_cnt_d = aon_cnt_q;
        rtt_d = rtt_q;
        if (async_q || (win_q != 8'h0))
        begin
            // Async path: no additive latency, timed from ODT sample
            if (odt != odt_q)
                aon_cnt_d = 4'(odt ? AONPD_MIN_CYC : AOFPD_MIN_CYC);
            else if (aon_cnt_q != 4'h0)
                aon_cnt_d = aon_cnt_q - 4'h1;
            if (aon_cnt_q == 4'h1)
                rtt_d = odt_q;
        end
        else
        begin
            aon_cnt_d = 4'h0;
            rtt_d = odt_hist_q[LAT];
        end
        if (zq_busy)
            rtt_d = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cke_q <= 1'b1;
            pd_q <= 1'b0;
            win_q <= 8'h0;
            rfc_q <= 8'h0;
            odt_hist_q <= 16'h0;
            async_q <= 1'b0;
            rtt_q <= 1'b0;
            aon_cnt_q <= 4'h0;
            odt_q <= 1'b0;
            win_open_q <= 1'b0;
        end
        else
        begin
            win_open_q <= (win_d != 8'h0);
            cke_q <= cke;
            pd_q <= pd_d;
            win_q <= win_d;
            rfc_q <= rfc_d;
            odt_hist_q <= odt_hist_d;
            async_q <= async_d;
            rtt_q <= rtt_d;
            aon_cnt_q <= aon_cnt_d;
            odt_q <= odt;
        end
    end

    // ************************************************************
    // Impedance calibration
    // ************************************************************
    odz_zq_e zq_q, zq_d;
    logic first_q, first_d;
    logic [7:0] code_q, code_d, eng_q, eng_d;
    logic tmr_load, tmr_busy, tmr_done;
    logic [CNT_W-1:0] tmr_val;

    odz_delay #(.W(CNT_W)) u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .value(tmr_val),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    always_comb
    begin
        zq_d = zq_q;
        first_d = first_q;
        code_d = code_q;
        eng_d = eng_q;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (zq_q)
            ODZ_ZQ_IDLE:
            begin
                // Only explicit commands start calibration
                if (zqcl_cmd)
                begin
                    zq_d = ODZ_ZQ_LONG;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(first_q ? ZQINIT - 1 : ZQOPER - 1);
                    first_d = 1'b0;
                end
                else if (zqcs_cmd)
                begin
                    zq_d = ODZ_ZQ_SHORT;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(ZQCS_STEP_NCK - 1);
                end
            end
            ODZ_ZQ_LONG, ODZ_ZQ_SHORT:
            begin
                eng_d = eng_q ^ 8'h01;
                if (tmr_done || !tmr_busy)
                    zq_d = ODZ_ZQ_LOAD;
            end
            ODZ_ZQ_LOAD:
            begin
                code_d = eng_q;
                zq_d = ODZ_ZQ_IDLE;
            end
            default: zq_d = ODZ_ZQ_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            zq_q <= ODZ_ZQ_IDLE;
            first_q <= 1'b1;
            code_q <= ZQ_CODE_RST;
            eng_q <= ZQ_CODE_RST;
        end
        else
        begin
            zq_q <= zq_d;
            first_q <= first_d;
            code_q <= code_d;
            eng_q <= eng_d;
        end
    end

    logic busy_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            busy_q <= 1'b0;
        else
            busy_q <= (zq_d != ODZ_ZQ_IDLE);
    end

    assign rtt_on = rtt_q;
    assign odt_async = async_q;
    assign in_window = win_open_q;
    assign zq_busy = busy_q;
    assign zq_current_en = busy_q;
    assign zq_code = code_q;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_ZQ_OFF_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (zq_q == ODZ_ZQ_IDLE && !zqcl_cmd && !zqcs_cmd) |=> !zq_current_en)
        else $error("calibration current left on");
    AST_ZQCS_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
        (zq_q == ODZ_ZQ_IDLE && zqcs_cmd && !zqcl_cmd) |=> zq_busy ##[1:70] !zq_busy)
        else $error("short calibration overran");
    AST_ZQ_LOADS: assert property (@(posedge clk) disable iff (!rst_n)
        (zq_q == ODZ_ZQ_LOAD) |=> (zq_code == $past(eng_q)))
        else $error("codes not loaded");
    AST_NO_SELF_CAL: assert property (@(posedge clk) disable iff (!rst_n)
        (zq_q == ODZ_ZQ_IDLE && !zqcl_cmd && !zqcs_cmd) |=> (zq_q == ODZ_ZQ_IDLE))
        else $error("calibration without command");
    AST_RTT_OFF_CAL: assert property (@(posedge clk) disable iff (!rst_n)
        zq_busy |=> !rtt_on)
        else $error("termination on during calibration");
    AST_ENTRY_WIN: assert property (@(posedge clk) disable iff (!rst_n)
        (dll_freeze_pd && cke_q && !cke && rfc_q == 8'h0) |=> in_window)
        else $error("entry window missing");
    AST_EXIT_WIN: assert property (@(posedge clk) disable iff (!rst_n)
        (pd_q && !cke_q && cke) |=> in_window)
        else $error("exit window missing");
    AST_SYNC_LAT: assert property (@(posedge clk) disable iff (!rst_n)
        (!async_q && win_q == 8'h0 && !zq_busy) |=> (rtt_on == $past(odt_hist_q[LAT])))
        else $error("synchronous latency wrong");
endmodule : odz_ctrl

//--- testbench/odz_ctrl_model.sv
// Behavioural memory controller driving power-down, termination and calibration
`timescale 1ns/1ps
module odz_ctrl_model
#(
    parameter int TRP = 3
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_pd,
    input wire logic req_odt,
    input wire logic req_ref,
    input wire logic req_zqcl,
    input wire logic req_zqcs,
    input wire logic rude,
    input wire logic zq_busy,
    output logic cke,
    output logic odt,
    output logic refresh_cmd,
    output logic zqcl_cmd,
    output logic zqcs_cmd
);
    logic init_q;
    logic [3:0] quiet_q;
    logic cal;
    logic free;
    assign cal = zq_busy || zqcl_cmd || zqcs_cmd;
    // Never enters self refresh, so no tXS wait precedes calibration
    // One device on the resistor; rude lets a scenario break in on purpose
    assign free = (!cal && quiet_q == 4'h0 && cke) || rude;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            init_q <= 1'b0;
            quiet_q <= 4'h0;
            cke <= 1'b1;
            odt <= 1'b0;
            refresh_cmd <= 1'b0;
            zqcl_cmd <= 1'b0;
            zqcs_cmd <= 1'b0;
        end
        else
        begin
            init_q <= init_q || free;
            zqcl_cmd <= free && (!init_q || req_zqcl);
            zqcs_cmd <= free && init_q && req_zqcs && !req_zqcl;
            refresh_cmd <= req_ref && !cal && cke;
            if (req_ref || zqcl_cmd || zqcs_cmd)
                quiet_q <= 4'(TRP);
            else if (quiet_q != 4'h0)
                quiet_q <= quiet_q - 4'h1;
            cke <= cal || !req_pd;
            odt <= req_odt && !cal;
        end
    end
endmodule : odz_ctrl_model

//--- testbench/tb_odz_ctrl.sv
// Self-checking bench of the termination mode and calibration controller
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_odz_ctrl
    import odz_pkg::*;
;
    localparam int ZI = 200;
    localparam int ZO = 100;
    localparam int WLV = 5;
    localparam int ALV = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic dll_freeze_pd = 1'b0;
    logic req_pd = 1'b0;
    logic req_odt = 1'b0;
    logic req_ref = 1'b0;
    logic req_zqcl = 1'b0;
    logic req_zqcs = 1'b0;
    logic rude = 1'b0;
    logic cke, odt, refresh_cmd, zqcl_cmd, zqcs_cmd;
    logic rtt_on, odt_async, in_window, zq_busy, zq_current_en;
    logic [7:0] zq_code;
    int fail_count = 0;
    int checks = 0;
    int seed = 18548;
    int n;
    int d;
    logic kind;
    odz_ctrl_model u_odz_ctrl_model (.clk(clk), .rst_n(rst_n), .req_pd(req_pd),
        .req_odt(req_odt), .req_ref(req_ref), .req_zqcl(req_zqcl), .req_zqcs(req_zqcs),
        .rude(rude), .zq_busy(zq_busy), .cke(cke), .odt(odt), .refresh_cmd(refresh_cmd),
        .zqcl_cmd(zqcl_cmd), .zqcs_cmd(zqcs_cmd));
    odz_ctrl #(.WL(WLV), .AL(ALV), .ZQINIT(ZI), .ZQOPER(ZO)) u_odz_ctrl (.clk(clk),
        .rst_n(rst_n), .dll_freeze_pd(dll_freeze_pd), .cke(cke), .odt(odt),
        .refresh_cmd(refresh_cmd), .zqcl_cmd(zqcl_cmd), .zqcs_cmd(zqcs_cmd),
        .rtt_on(rtt_on), .odt_async(odt_async), .in_window(in_window), .zq_busy(zq_busy),
        .zq_current_en(zq_current_en), .zq_code(zq_code));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick
    // Length of the next high run of busy (sel 0) or window (sel 1)
    task automatic run_len(input bit sel, output int len);
        int k;
        len = 0;
        k = 0;
        @(negedge clk);
        while (((sel ? in_window : zq_busy) !== 1'b1) && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        while (((sel ? in_window : zq_busy) === 1'b1) && len < 400)
        begin
            @(negedge clk);
            len++;
        end
    endtask : run_len
    // Cycles from termination request to matching output, model stage included
    task automatic odt_step(input logic v, output int dl);
        @(posedge clk) req_odt <= v;
        dl = -1;
        while (rtt_on !== v && dl < 40)
        begin
            @(negedge clk);
            dl++;
        end
    endtask : odt_step
    task automatic pd(input logic v);
        @(posedge clk) req_pd <= v;
    endtask : pd
    task automatic give_verdict();
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // ************************************************************
    // Monitors and watchdog
    // ************************************************************
    always @(negedge clk)
    begin
        if (rst_n)
            `CHK(zq_current_en, zq_busy)
    end
    initial
    begin
        #(20000 * 5);
        fail_count++;
        give_verdict();
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clk);
        `CHK(zq_code, 8'h80)
        @(posedge clk) rst_n <= 1'b1;
        run_len(1'b0, n);
        `CHK(n > ZO + 3 && n <= ZI + 3, 1'b1)
        for (int i = 0; i < 6; i++)
        begin
            kind = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($random(seed));
            tick(1 + ($unsigned($random(seed)) % 8));
            @(posedge clk);
            req_zqcl <= kind;
            req_zqcs <= !kind;
            fork
                run_len(1'b0, n);
                begin
                    @(posedge clk);
                    req_zqcl <= 1'b0;
                    req_zqcs <= 1'b0;
                    if (i == 1)
                    begin
                        tick(10);
                        rude <= 1'b1;
                        req_zqcs <= 1'b1;
                        @(posedge clk);
                        rude <= 1'b0;
                        req_zqcs <= 1'b0;
                    end
                end
            join
            if (kind)
                `CHK(n > ZQCS_CYC + 3 && n <= ZO + 3, 1'b1)
            else
                `CHK(n >= ZQCS_STEP_NCK && n <= ZQCS_CYC + 3, 1'b1)
        end
        tick(30);
        `CHK(zq_busy, 1'b0)
        fork
            run_len(1'b1, n);
            pd(1'b1);
        join
        `CHK(n, 0)
        `CHK(odt_async, 1'b0)
        pd(1'b0);
        tick(20);
        dll_freeze_pd <= 1'b1;
        fork
            run_len(1'b1, n);
            pd(1'b1);
        join
        `CHK(n >= CPDED_DEF && n <= CPDED_DEF + 2, 1'b1)
        tick(5);
        `CHK(odt_async, 1'b1)
        odt_step(1'b1, d);
        `CHK(d >= AONPD_MIN_CYC && d <= WLV + 1, 1'b1)
        odt_step(1'b0, d);
        `CHK(d >= AOFPD_MIN_CYC && d <= WLV + 1, 1'b1)
        fork
            run_len(1'b1, n);
            pd(1'b0);
        join
        `CHK(n >= XPDLL_DEF - 1 && n <= XPDLL_DEF + 2, 1'b1)
        tick(5);
        `CHK(odt_async, 1'b0)
        odt_step(1'b1, d);
        `CHK(d >= WLV + ALV - 2 && d <= WLV + ALV + 2, 1'b1)
        odt_step(1'b0, d);
        `CHK(d >= WLV + ALV - 2 && d <= WLV + ALV + 2, 1'b1)
        @(posedge clk) req_ref <= 1'b1;
        @(posedge clk) req_ref <= 1'b0;
        fork
            run_len(1'b1, n);
            begin
                tick(2);
                req_pd <= 1'b1;
            end
        join
        `CHK(n >= RFC_DEF - 6 && n <= RFC_DEF + 2, 1'b1)
        pd(1'b0);
        tick(30);
        // Refresh keeps the entry window open across a quick exit
        @(posedge clk) req_ref <= 1'b1;
        @(posedge clk) req_ref <= 1'b0;
        fork
            run_len(1'b1, n);
            begin
                pd(1'b1);
                tick(3);
                req_pd <= 1'b0;
                tick(3);
                req_pd <= 1'b1;
            end
        join
        `CHK(n >= XPDLL_DEF + CPDED_DEF, 1'b1)
        pd(1'b0);
        tick(30);
        give_verdict();
    end
endmodule : tb_odz_ctrl
